/* pkg/rdt_pkg.sv */
// Package: register map, encodings and timing for the remote diode readout
package rdt_pkg;

  // ------------------------------------------------------------
  // Register map (word indices; byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_REMOTE1_VALUE = 8'h25;
  localparam logic [7:0] ADDR_REMOTE2_VALUE = 8'h27;
  localparam logic [7:0] ADDR_FRACTION      = 8'h77;
  localparam logic [7:0] ADDR_CONFIG        = 8'h7c;
  localparam logic [7:0] ADDR_STATUS        = 8'h80;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int         CFG_OFFSET64_BIT = 0;
  localparam int         CFG_ENABLE_BIT   = 1;
  localparam logic [7:0] CFG_RESET        = 8'h02;
  localparam int         FRAC_R1_LSB      = 2;
  localparam int         FRAC_R2_LSB      = 4;
  localparam logic [7:0] VALUE_RESET      = 8'h00;

  // ------------------------------------------------------------
  // Encoding constants
  // ------------------------------------------------------------
  localparam logic [7:0] TWOS_FAULT_CODE = 8'h80;
  localparam logic [7:0] OFS64_FAULT_CODE = 8'h00;
  localparam logic [9:0] OFS64_BIAS      = 10'h100;
  localparam int         TWOS_MAX_DEG    = 127;
  localparam int         TWOS_MIN_DEG    = -127;
  localparam int         OFS_MAX_DEG     = 191;
  localparam int         OFS_MIN_DEG     = -63;

  // ------------------------------------------------------------
  // Timing: bias settling per step
  // ------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int SETTLE_US     = 10;
  localparam int SETTLE_CYCLES = (SETTLE_US * CLK_MHZ < 1) ? 1 : SETTLE_US * CLK_MHZ;
  localparam int AVG_COUNT     = 16;

  // Bias levels driven to the analog front end
  typedef enum logic [1:0] {
    RDT_BIAS_BASE = 2'h0,
    RDT_BIAS_N1   = 2'h1,
    RDT_BIAS_N2   = 2'h2
  } rdt_bias_t;

  // Per-sample result from the analog converter
  typedef struct packed {
    logic       fault;
    logic [9:0] quarter_deg;
  } rdt_sample_t;

endpackage

/* hdl/rdt_encode.sv */
// Encoder: signed quarter-degree result to register byte and fraction bits
`timescale 1ns/1ps
module rdt_encode (
  input  wire logic       offset64,
  input  wire logic       fault,
  input  wire logic [9:0] quarter_deg,
  output logic      [7:0] value_byte,
  output logic      [1:0] frac_bits
);
  import rdt_pkg::*;

  logic signed [7:0] whole;
  logic        [9:0] biased;

  // Apply chosen encoding, replace with fault code on fault, on -128 (twos) or below -63 (offset-64)
  always_comb begin
    whole  = $signed(quarter_deg[9:2]);
    biased = quarter_deg + OFS64_BIAS;
    frac_bits = quarter_deg[1:0];
    if (offset64) begin
      value_byte = biased[9:2];
      if (fault || $signed(quarter_deg[9:2]) < OFS_MIN_DEG) begin
        value_byte = OFS64_FAULT_CODE;
        frac_bits  = 2'h0;
      end
    end else begin
      value_byte = whole;
      if (fault || whole == TWOS_FAULT_CODE) begin
        value_byte = TWOS_FAULT_CODE;
        frac_bits  = 2'h0;
      end
    end
  end
endmodule

/* hdl/rdt_readout.sv */
// Remote diode readout: bias sequencing, averaging, encoding and AXI4-Lite registers
`timescale 1ns/1ps
module rdt_readout (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // Analog front end
  output logic                          bias_sel_q,
  output rdt_pkg::rdt_bias_t            bias_level_q,
  output logic                          sample_req_q,
  input  wire logic                     sample_valid,
  input  wire rdt_pkg::rdt_sample_t     sample_dv1,
  input  wire rdt_pkg::rdt_sample_t     sample_dv2,
  // AXI4-Lite slave
  input  wire logic [9:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [9:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  import rdt_pkg::*;
  parameter int NUM_CH  = 2;
  parameter int AVG_LOG = 4;
  initial begin
    if (NUM_CH != 2) $error("Only two remote channels are mapped");
    if ((1 << AVG_LOG) != AVG_COUNT) $error("Averaging depth must be sixteen");
  end
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_BASE1 = 5'b00001,
    ST_HIGH1 = 5'b00010,
    ST_BASE2 = 5'b00100,
    ST_HIGH2 = 5'b01000,
    ST_WAIT  = 5'b10000
  } rdt_state_t;
  rdt_state_t  state_q;
  logic [15:0] settle_q;
  logic [3:0]  avg_cnt_q;
  logic [7:0]  cfg_q;
  logic        sv_s1_q;
  logic        sv_s2_q;
  logic        sv_prev_q;
  logic        sample_stb;
  // Two-flop sync of the converter's done level, then edge detect
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sv_s1_q   <= 1'b0;
      sv_s2_q   <= 1'b0;
      sv_prev_q <= 1'b0;
    end else if (clk_en) begin
      sv_s1_q   <= sample_valid;
      sv_s2_q   <= sv_s1_q;
      sv_prev_q <= sv_s2_q;
    end
  end
  assign sample_stb = sv_s2_q & ~sv_prev_q;
  // Bias step walk: base, N1, base, N2, then convert
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q      <= ST_BASE1;
      settle_q     <= 16'h0000;
      bias_level_q <= RDT_BIAS_BASE;
      sample_req_q <= 1'b0;
    end else if (clk_en) begin
      sample_req_q <= 1'b0;
      if (state_q != ST_WAIT && cfg_q[CFG_ENABLE_BIT]) begin
        if (settle_q == 16'(SETTLE_CYCLES - 1)) begin
          settle_q <= 16'h0000;
          unique case (state_q)
            ST_BASE1: begin
              state_q      <= ST_HIGH1;
              bias_level_q <= RDT_BIAS_N1;
            end
            ST_HIGH1: begin
              state_q      <= ST_BASE2;
              bias_level_q <= RDT_BIAS_BASE;
            end
            ST_BASE2: begin
              state_q      <= ST_HIGH2;
              bias_level_q <= RDT_BIAS_N2;
            end
            ST_HIGH2: begin
              state_q      <= ST_WAIT;
              bias_level_q <= RDT_BIAS_BASE;
              sample_req_q <= 1'b1;
            end
            default: state_q <= ST_BASE1;
          endcase
        end else begin
          settle_q <= settle_q + 16'h0001;
        end
      end else if (state_q == ST_WAIT && sample_stb) begin
        state_q <= ST_BASE1;
      end
    end
  end
  // Channel select flips after each group of sixteen cycles
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bias_sel_q <= 1'b0;
    end else if (clk_en && sample_stb && state_q == ST_WAIT && avg_cnt_q == 4'hf) begin
      bias_sel_q <= ~bias_sel_q;
    end
  end

  // ------------------------------------------------------------
  // Averaging: combine both differences, accumulate sixteen
  // ------------------------------------------------------------
  logic signed [10:0] combined;
  logic signed [14:0] acc_q;
  logic               fault_acc_q;
  logic signed [14:0] acc_next;
  logic               done_pulse;
  // Two bias differences averaged into one quarter-degree figure
  assign combined   = ($signed({sample_dv1.quarter_deg[9], sample_dv1.quarter_deg})
                     + $signed({sample_dv2.quarter_deg[9], sample_dv2.quarter_deg})) >>> 1;
  assign acc_next   = acc_q + 15'(combined);
  assign done_pulse = sample_stb && state_q == ST_WAIT && avg_cnt_q == 4'hf;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acc_q       <= 15'h0000;
      avg_cnt_q   <= 4'h0;
      fault_acc_q <= 1'b0;
    end else if (clk_en && sample_stb && state_q == ST_WAIT) begin
      avg_cnt_q <= avg_cnt_q + 4'h1;
      if (avg_cnt_q == 4'hf) begin
        acc_q       <= 15'h0000;
        fault_acc_q <= 1'b0;
      end else begin
        acc_q       <= acc_next;
        fault_acc_q <= fault_acc_q | sample_dv1.fault | sample_dv2.fault;
      end
    end
  end

  // ------------------------------------------------------------
  // Encoding and result registers
  // ------------------------------------------------------------
  logic [9:0] avg_result;
  logic       avg_fault;
  logic [7:0] enc_value;
  logic [1:0] enc_frac;
  logic [7:0] value_q [NUM_CH];
  logic [1:0] frac_q  [NUM_CH];
  logic [9:0] raw_q   [NUM_CH];
  logic       flt_q   [NUM_CH];
  logic       frozen_q;
  logic [2:0] pend_q;
  assign avg_result = acc_next[13:4];
  assign avg_fault  = fault_acc_q | sample_dv1.fault | sample_dv2.fault;
  // Raw result kept per channel so encoding change applies at once
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          raw_q[c] <= 10'h000;
          flt_q[c] <= 1'b1;
        end else if (clk_en && done_pulse && bias_sel_q == 1'(c)) begin
          raw_q[c] <= avg_result;
          flt_q[c] <= avg_fault;
        end
      end
      logic [7:0] ev;
      logic [1:0] ef;
      rdt_encode u_enc (
        .offset64    (cfg_q[CFG_OFFSET64_BIT]),
        .fault       (flt_q[c]),
        .quarter_deg (raw_q[c]),
        .value_byte  (ev),
        .frac_bits   (ef)
      );
      // Reading registers track the encoder unless frozen
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          value_q[c] <= VALUE_RESET;
          frac_q[c]  <= 2'h0;
        end else if (clk_en && !frozen_q) begin
          value_q[c] <= ev;
          frac_q[c]  <= ef;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic aw_hold_q;
  logic w_hold_q;
  logic [9:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic       wstrb0_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 10'h000;
      wbyte_q       <= 8'h00;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      cfg_q         <= CFG_RESET;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q[9:2] == ADDR_CONFIG) begin
          s_axi_bresp <= 2'h0;
          if (wstrb0_q) begin
            cfg_q <= wbyte_q & 8'h03;
          end
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel and freeze tracking
  // ------------------------------------------------------------
  logic [7:0] raddr;
  assign raddr = s_axi_araddr[9:2];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      frozen_q      <= 1'b0;
      pend_q        <= 3'h0;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        s_axi_rdata  <= 32'h0000_0000;
        unique case (raddr)
          ADDR_REMOTE1_VALUE: begin
            s_axi_rdata[7:0] <= value_q[0];
            if (frozen_q && pend_q == 3'h2) frozen_q <= 1'b0;
            pend_q <= pend_q & 3'b101;
          end
          ADDR_REMOTE2_VALUE: begin
            s_axi_rdata[7:0] <= value_q[1];
            if (frozen_q && pend_q == 3'h4) frozen_q <= 1'b0;
            pend_q <= pend_q & 3'b011;
          end
          ADDR_FRACTION: begin
            s_axi_rdata[FRAC_R1_LSB +: 2] <= frac_q[0];
            s_axi_rdata[FRAC_R2_LSB +: 2] <= frac_q[1];
            frozen_q <= 1'b1;
            pend_q   <= 3'h6;
          end
          ADDR_CONFIG: s_axi_rdata[7:0] <= cfg_q;
          ADDR_STATUS: s_axi_rdata[7:0] <= {5'h00, frozen_q, flt_q[1], flt_q[0]};
          default:     s_axi_rresp <= 2'h2;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_frac_read;
    s_axi_arvalid && s_axi_arready && raddr == ADDR_FRACTION && clk_en;
  endsequence

  a_freeze_on_frac: assert property (@(posedge mclk) disable iff (!rst_n)
    s_frac_read |=> frozen_q) else $error("Fraction read did not freeze readings");
  a_frozen_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    frozen_q && $past(frozen_q) |-> $stable(value_q[0]) && $stable(value_q[1])
      && $stable(frac_q[0]) && $stable(frac_q[1]))
    else $error("Reading changed while frozen");
  a_twos_fault_code: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_q[CFG_OFFSET64_BIT] && flt_q[0] && !frozen_q && clk_en |=> value_q[0] == TWOS_FAULT_CODE)
    else $error("Twos complement fault code wrong");
  a_ofs_fault_code: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q[CFG_OFFSET64_BIT] && flt_q[0] && !frozen_q && clk_en |=> value_q[0] == OFS64_FAULT_CODE)
    else $error("Offset-64 fault code wrong");
  a_avg_sixteen: assert property (@(posedge mclk) disable iff (!rst_n)
    done_pulse && clk_en |=> bias_sel_q != $past(bias_sel_q) && avg_cnt_q == 4'h0)
    else $error("Update before sixteen cycles");
  a_bias_order: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_HIGH1 |-> bias_level_q == RDT_BIAS_N1) else $error("N1 bias step wrong");
  a_bias_second: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == ST_HIGH2 |-> bias_level_q == RDT_BIAS_N2) else $error("N2 bias step wrong");
  a_bresp_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    aw_hold_q && w_hold_q && !s_axi_bvalid && clk_en && wstrb0_q && awaddr_q[9:2] == ADDR_CONFIG
    |=> s_axi_bvalid && s_axi_bresp == 2'h0 && cfg_q[CFG_OFFSET64_BIT] == $past(wbyte_q[0]))
    else $error("Encoding select write not applied");
endmodule

/* tb/rdt_diode_model.sv */
// Behavioural remote diode and converter answering the readout's bias walk
`timescale 1ns/1ps
module rdt_diode_model (
  input  wire logic                 mclk,
  input  wire logic                 bias_sel,
  input  wire rdt_pkg::rdt_bias_t   bias_level,
  input  wire logic                 sample_req,
  input  wire logic [9:0]           t1,
  input  wire logic [9:0]           t2,
  input  wire logic                 f1,
  output logic                      sample_valid,
  output rdt_pkg::rdt_sample_t      dv1,
  output rdt_pkg::rdt_sample_t      dv2,
  output int                        walk_err,
  output int                        req_cnt
);
  import rdt_pkg::*;
  logic       seen1 = 1'b0;
  logic       seen2 = 1'b0;
  logic       pend  = 1'b0;
  logic       fsel  = 1'b0;
  logic [9:0] d1    = 10'h000;
  logic [9:0] d2    = 10'h000;
  int         wait_n = 0;
  int         hold_n = 0;
  initial begin
    sample_valid = 1'b0;
    walk_err = 0;
    req_cnt = 0;
  end
  // --------------------------------------------------------
  // Bias walk check and conversion answer
  // --------------------------------------------------------
  // Samples alternate +-0.5 degree so only a true mean lands on the set value
  always @(posedge mclk) begin
    if (bias_level == RDT_BIAS_N1) seen1 <= 1'b1;
    if (bias_level == RDT_BIAS_N2) seen2 <= 1'b1;
    if (sample_req) begin
      if (!(seen1 && seen2)) walk_err <= walk_err + 1;
      seen1 <= 1'b0;
      seen2 <= 1'b0;
      req_cnt <= req_cnt + 1;
      // Both differences describe the selected channel; only remote 1 can fault
      d1 <= (bias_sel ? t2 : t1) + (req_cnt[1] ? 10'h002 : 10'h3fe);
      d2 <= (bias_sel ? t2 : t1) + (req_cnt[1] ? 10'h002 : 10'h3fe);
      fsel <= f1 && !bias_sel;
      wait_n <= req_cnt[2] ? 2 : 20; // Prompt and slow answers
      pend <= 1'b1;
    end else if (pend) begin
      if (wait_n > 0) wait_n <= wait_n - 1;
      else begin
        pend <= 1'b0;
        sample_valid <= 1'b1;
        hold_n <= 6;
      end
    end else if (sample_valid) begin
      if (hold_n > 0) hold_n <= hold_n - 1;
      else sample_valid <= 1'b0;
    end
  end
  // Outside the valid window the lines show the inverse, never stale data
  assign dv1 = sample_valid ? {fsel, d1} : {~fsel, ~d1};
  assign dv2 = sample_valid ? {1'b0, d2} : {1'b1, ~d2};
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the remote diode readout
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
  import rdt_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n, clk_en, bias_sel_q, sample_req_q, sample_valid, f1;
  rdt_bias_t   bias_level_q;
  rdt_sample_t dv1, dv2;
  logic [9:0]  t1, t2;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          walk_err, req_cnt;
  typedef struct {logic [9:0] t1, t2; logic f1, mode; logic [7:0] v1, v2, fr;} rdt_row_t;
  rdt_row_t rows [4] = '{
    '{10'h0cb, 10'h39c, 1'b0, 1'b0, 8'h32, 8'he7, 8'h0c},
    '{10'h0cb, 10'h39c, 1'b0, 1'b1, 8'h72, 8'h27, 8'h0c},
    '{10'h0cb, 10'h1fc, 1'b1, 1'b0, 8'h80, 8'h7f, 8'h00},
    '{10'h0cb, 10'h1fc, 1'b1, 1'b1, 8'h00, 8'hbf, 8'h00}};
  // --------------------------------------------------------
  // Clock, design and far-side model
  // --------------------------------------------------------
  always #20 mclk = ~mclk;
  rdt_readout #(.NUM_CH(2), .AVG_LOG(4)) i_rdt_readout (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .bias_sel_q(bias_sel_q), .bias_level_q(bias_level_q), .sample_req_q(sample_req_q),
    .sample_valid(sample_valid), .sample_dv1(dv1), .sample_dv2(dv2),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  rdt_diode_model i_rdt_diode_model (.mclk(mclk), .bias_sel(bias_sel_q), .bias_level(bias_level_q),
    .sample_req(sample_req_q), .t1(t1), .t2(t2), .f1(f1), .sample_valid(sample_valid), .dv1(dv1),
    .dv2(dv2), .walk_err(walk_err), .req_cnt(req_cnt));
  // --------------------------------------------------------
  // Bus tasks and closing report
  // --------------------------------------------------------
  // Offsets are register indices, so the byte address is four times them
  function automatic logic [9:0] wa(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'h1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Two full averaging periods fit well inside this ceiling
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      stop_test();
    end
  end
  // --------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------
  initial begin
    logic [31:0] d1, d2, d;
    logic [1:0]  r;
    rst_n = 1'b0; clk_en = 1'b1; t1 = 10'h000; t2 = 10'h000; f1 = 1'b0;
    awaddr = 10'h000; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 10'h000; arvalid = 1'b0; rready = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    axi_rd(wa(ADDR_CONFIG), d, r);
    `CHK(d[7:0], CFG_RESET)
    `CHK(r, 2'h0)
    $display("Test reset done");
    // Each twos row loads new diode figures and waits for the averaged update
    foreach (rows[i]) begin
      if (!rows[i].mode) begin
        t1 <= rows[i].t1; t2 <= rows[i].t2; f1 <= rows[i].f1;
        axi_wr(wa(ADDR_CONFIG), 32'h2, r);
        do begin
          repeat (200) @(posedge mclk);
          axi_rd(wa(ADDR_REMOTE1_VALUE), d1, r);
          axi_rd(wa(ADDR_REMOTE2_VALUE), d2, r);
        end while (d1[7:0] !== rows[i].v1 || d2[7:0] !== rows[i].v2);
      end
      axi_wr(wa(ADDR_CONFIG), {30'h0, 1'b1, rows[i].mode}, r);
      `CHK(r, 2'h0)
      axi_rd(wa(ADDR_FRACTION), d, r);
      `CHK(d[7:0], rows[i].fr)
      axi_rd(wa(ADDR_REMOTE1_VALUE), d1, r);
      `CHK(d1[7:0], rows[i].v1)
      axi_rd(wa(ADDR_REMOTE2_VALUE), d2, r);
      `CHK(d2[7:0], rows[i].v2)
      $display("Test row %0d done", i);
    end
    // Refused accesses: unmapped read and write, write to a read-only place
    axi_rd(10'h040, d, r);
    `CHK(r, 2'h2)
    axi_wr(10'h040, 32'h1, r);
    `CHK(r, 2'h2)
    axi_wr(wa(ADDR_FRACTION), 32'hff, r);
    `CHK(r, 2'h2)
    $display("Test refusals done");
    // Fraction read freezes readings until both value registers are read
    axi_rd(wa(ADDR_FRACTION), d, r);
    axi_rd(wa(ADDR_STATUS), d, r);
    `CHK(d[7:0], 8'h05)
    axi_rd(wa(ADDR_REMOTE1_VALUE), d1, r);
    axi_rd(wa(ADDR_STATUS), d, r);
    `CHK(d[7:0], 8'h05)
    axi_rd(wa(ADDR_REMOTE2_VALUE), d2, r);
    axi_rd(wa(ADDR_STATUS), d, r);
    `CHK(d[7:0], 8'h01)
    $display("Test freeze done");
    `CHK(walk_err, 0)
    `CHK(req_cnt > 0, 1'b1)
    $display("Test bias walk done");
    stop_test();
  end
endmodule
